// file: pmd_pkg.sv
// constants, field layout and state types of the mii duplex/loopback/bist core
// assumes a single 40 MHz clock domain; link pins are sampled, not clocked
// Summary of operation
// - half duplex: carrier sense covers transmit too
// - full duplex: no collisions, carrier is receive-only
// - other mii signals ignore duplex mode
// - loopback bit routes transmit nibbles to receive
// - loopback state readable in phy status
// - nothing reaches the medium during loopback
// - self-test sends prbs, 9 or 15 bits
// - independent receive lfsr checks received data
// - pass bit resets to fail, sets on success
// - mismatch latched until start/stop bit written
// - continuous bit makes self-test send unbroken
// - eight-bit error count in cable diag upper byte
// - receive side: rxd, rx_er, rx_dv, rx_clk
// - mac drives txd/tx_en, device supplies tx_clk
// - half duplex: tx and rx together raise col, except in loopback
// - 10 Mb/s transmit collision waits seven bits
// - col holds while the collision lasts
// - collision starting in receive reported at once
// - heartbeat pulses col ten bits, 1 us after
// - 100 Mb/s carrier needs detect plus two zeros
// - 10 Mb/s carrier follows squelch valid data
// - thirty-two 16-bit registers in management space
`default_nettype none
package pmd_pkg;
  localparam int REG_AW = 5;
  localparam int REG_DW = 16;
  localparam logic [4:0] ADDR_BASIC_CTRL = 5'h00;
  localparam logic [4:0] ADDR_PHY_STATUS = 5'h10;
  localparam logic [4:0] ADDR_PHY_CTRL = 5'h19;
  localparam logic [4:0] ADDR_CABLE_DIAG = 5'h1B;
  localparam int BC_LOOPBACK_BIT = 14;
  localparam int BC_SPEED_BIT = 13;
  localparam int BC_DUPLEX_BIT = 8;
  localparam int PS_LOOPBACK_BIT = 3;
  localparam int PS_DUPLEX_BIT = 2;
  localparam int PS_SPEED10_BIT = 1;
  localparam int PS_LINK_BIT = 0;
  localparam int PC_PRBS_LEN_BIT = 10;
  localparam int PC_BIST_STATUS_BIT = 9;
  localparam int PC_BIST_START_BIT = 8;
  localparam int PC_HEARTBEAT_BIT = 7;
  localparam int CD_CONT_BIT = 5;
  localparam int CD_ERR_LSB = 8;
  localparam logic [15:0] BASIC_CTRL_RST = 16'h2000;
  localparam logic [15:0] PHY_CTRL_RST = 16'h0000;
  localparam logic [15:0] CABLE_DIAG_RST = 16'h0000;
  // timing, all derived from the 25 ns clock period
  localparam int CLK_NS = 25;
  localparam int BIT10_NS = 100;
  localparam int COL_DELAY_BITS = 7;
  localparam logic [5:0] COL_DELAY_CYC =
    6'((COL_DELAY_BITS * BIT10_NS + CLK_NS - 1) / CLK_NS);
  localparam int HB_DELAY_NS = 1000;
  localparam logic [5:0] HB_DELAY_CYC = 6'(HB_DELAY_NS / CLK_NS);
  localparam int HB_WIDTH_BITS = 10;
  localparam logic [5:0] HB_WIDTH_CYC =
    6'(HB_WIDTH_BITS * BIT10_NS / CLK_NS);
  // self-test framing, in nibbles
  localparam logic [7:0] PKT_NIBBLES = 8'hC8;
  localparam logic [7:0] GAP_NIBBLES = 8'h18;
  localparam logic [7:0] PASS_NIBBLES = 8'h20;
  localparam logic [2:0] CHK_FILL = 3'h4;
  localparam logic [14:0] PRBS_SEED = 15'h7FFF;
  typedef enum logic [2:0] {
    BT_IDLE = 3'b001, BT_DATA = 3'b010, BT_GAP = 3'b100
  } pmd_bt_type;
  typedef enum logic [2:0] {
    HB_IDLE = 3'b001, HB_WAIT = 3'b010, HB_PULSE = 3'b100
  } pmd_hb_type;
endpackage
`default_nettype wire

// file: pmd_mii_core.sv
// mii-facing core: carrier/collision, loopback, prbs self-test, registers
// assumes link_clk and all pin inputs are asynchronous to clock
`timescale 1ns/1ps
`default_nettype none
module pmd_mii_core (
  input wire logic clock, // 40 MHz core clock
  input wire logic rst_n, // async reset, active low
  input wire logic [pmd_pkg::REG_AW-1:0] reg_addr, // register index
  input wire logic [pmd_pkg::REG_DW-1:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [pmd_pkg::REG_DW-1:0] reg_rdata, // read data, next cycle
  input wire logic link_clk, // nibble clock from the medium side
  input wire logic [3:0] mac_txd, // mac transmit nibble
  input wire logic mac_tx_en, // mac transmit enable
  output logic tx_clk, // transmit clock to mac
  output logic rx_clk, // receive clock to mac
  output logic [3:0] rxd, // receive nibble
  output logic rx_dv, // receive data valid
  output logic rx_er, // receive error
  output logic crs, // carrier sense
  output logic col, // collision
  input wire logic [3:0] med_rxd, // nibble decoded from the medium
  input wire logic med_rx_dv, // medium data valid
  input wire logic med_rx_er, // medium symbol error
  input wire logic signal_detect, // 100 Mb/s signal detect
  input wire logic squelch_valid, // 10 Mb/s squelch passed
  input wire logic med_line_bit, // 100 Mb/s line bit stream
  output logic [3:0] med_txd, // nibble toward the medium
  output logic med_tx_en // transmit enable toward the medium
);
  import pmd_pkg::*;

  // one feedback bit of the 9 or 15 bit prbs
  function automatic logic prbs_tap(input logic [14:0] s,
                                    input logic l15);
    prbs_tap = l15 ? (s[14] ^ s[13]) : (s[8] ^ s[4]);
  endfunction

  // advance the generator by one nibble
  function automatic logic [14:0] prbs_next(input logic [14:0] s,
                                            input logic l15);
    logic [14:0] t;
    t = s;
    for (int i = 0; i < 4; i++) begin
      t = {t[13:0], prbs_tap(t, l15)};
    end
    prbs_next = t;
  endfunction

  // shift a received nibble in, msb first; bit 15 flags a miscompare
  function automatic logic [15:0] prbs_check(input logic [14:0] s,
                                             input logic [3:0] d,
                                             input logic l15);
    logic [14:0] t;
    logic e;
    t = s;
    e = 1'b0;
    for (int i = 3; i >= 0; i--) begin
      e = e | (prbs_tap(t, l15) != d[i]);
      t = {t[13:0], d[i]};
    end
    prbs_check = {e, t};
  endfunction

  logic [14:0] sync1_q, sync2_q;
  logic s_lclk, s_txen, s_mdv, s_mer, s_sd, s_sq, s_line;
  logic [3:0] s_txd, s_mrxd;
  logic lclk_prev_q, tick;
  logic loopback_q, speed100_q, full_dup_q;
  logic prbs15_q, bist_start_q, hb_en_q, cont_q;
  logic [7:0] err_cnt_q, err_base;
  logic bist_pass_q, bist_fail_q, pc_wr;
  logic [15:0] rd_d, rdata_q;
  pmd_bt_type bt_q;
  logic [7:0] bt_cnt_q;
  logic [14:0] gen_q, chk_q;
  logic [2:0] chk_fill_q;
  logic [7:0] good_cnt_q;
  logic tx_en_src, rx_dv_src, rx_er_src;
  logic [3:0] txd_src, rxd_src;
  logic chk_miss, chk_on, mismatch, good;
  logic [14:0] chk_d;
  logic tx_act_q, tx_prev_q, rx_act, rx_prev_q;
  logic car100_q, zero_q, one_q, dv_prev_q;
  logic coll_raw, coll_prev_q, col_dly_q, dly_now, col_live;
  logic [5:0] col_cnt_q, hb_cnt_q;
  pmd_hb_type hb_q;
  logic tx_clk_q, rx_clk_q, rx_dv_q, rx_er_q, crs_q, col_q;
  logic [3:0] rxd_q, med_txd_q;
  logic med_tx_en_q;

  // two flops on every pin input; only sync2_q is ever looked at
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 15'h0000;
      sync2_q <= 15'h0000;
    end else begin
      sync1_q <= {link_clk, mac_txd, mac_tx_en, med_rxd, med_rx_dv,
                  med_rx_er, signal_detect, squelch_valid, med_line_bit};
      sync2_q <= sync1_q;
    end
  end
  assign {s_lclk, s_txd, s_txen, s_mrxd, s_mdv, s_mer, s_sd, s_sq,
          s_line} = sync2_q;

  // rising edge of the link clock marks one nibble time
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lclk_prev_q <= 1'b0;
    end else begin
      lclk_prev_q <= s_lclk;
    end
  end
  assign tick = s_lclk & ~lclk_prev_q;

  // software-written controls; 32-entry space, unlisted indexes ignore
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      loopback_q <= BASIC_CTRL_RST[BC_LOOPBACK_BIT];
      speed100_q <= BASIC_CTRL_RST[BC_SPEED_BIT];
      full_dup_q <= BASIC_CTRL_RST[BC_DUPLEX_BIT];
      prbs15_q <= PHY_CTRL_RST[PC_PRBS_LEN_BIT];
      bist_start_q <= PHY_CTRL_RST[PC_BIST_START_BIT];
      hb_en_q <= PHY_CTRL_RST[PC_HEARTBEAT_BIT];
      cont_q <= CABLE_DIAG_RST[CD_CONT_BIT];
    end else if (reg_wr) begin
      case (reg_addr)
        ADDR_BASIC_CTRL: begin
          loopback_q <= reg_wdata[BC_LOOPBACK_BIT];
          speed100_q <= reg_wdata[BC_SPEED_BIT];
          full_dup_q <= reg_wdata[BC_DUPLEX_BIT];
        end
        ADDR_PHY_CTRL: begin
          prbs15_q <= reg_wdata[PC_PRBS_LEN_BIT];
          bist_start_q <= reg_wdata[PC_BIST_START_BIT];
          hb_en_q <= reg_wdata[PC_HEARTBEAT_BIT];
        end
        ADDR_CABLE_DIAG: begin
          cont_q <= reg_wdata[CD_CONT_BIT];
        end
        default: begin
        end
      endcase
    end
  end
  assign pc_wr = reg_wr && (reg_addr == ADDR_PHY_CTRL);

  // read mux; unmapped indexes return zero
  always_comb begin
    rd_d = 16'h0000;
    case (reg_addr)
      ADDR_BASIC_CTRL: begin
        rd_d[BC_LOOPBACK_BIT] = loopback_q;
        rd_d[BC_SPEED_BIT] = speed100_q;
        rd_d[BC_DUPLEX_BIT] = full_dup_q;
      end
      ADDR_PHY_STATUS: begin
        rd_d[PS_LOOPBACK_BIT] = loopback_q;
        rd_d[PS_DUPLEX_BIT] = full_dup_q;
        rd_d[PS_SPEED10_BIT] = ~speed100_q;
        rd_d[PS_LINK_BIT] = s_sd;
      end
      ADDR_PHY_CTRL: begin
        rd_d[PC_PRBS_LEN_BIT] = prbs15_q;
        rd_d[PC_BIST_STATUS_BIT] = bist_pass_q;
        rd_d[PC_BIST_START_BIT] = bist_start_q;
        rd_d[PC_HEARTBEAT_BIT] = hb_en_q;
      end
      ADDR_CABLE_DIAG: begin
        rd_d[CD_CONT_BIT] = cont_q;
        rd_d[CD_ERR_LSB +: 8] = err_cnt_q;
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= reg_rd ? rd_d : 16'h0000;
    end
  end

  // self-test transmitter: packets with gaps, or unbroken when continuous
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bt_q <= BT_IDLE;
      bt_cnt_q <= 8'h00;
      gen_q <= PRBS_SEED;
    end else if (!bist_start_q) begin
      bt_q <= BT_IDLE;
      bt_cnt_q <= 8'h00;
      gen_q <= PRBS_SEED;
    end else if (tick) begin
      case (bt_q)
        BT_IDLE: begin
          bt_q <= BT_DATA;
          bt_cnt_q <= 8'h00;
        end
        BT_DATA: begin
          gen_q <= prbs_next(gen_q, prbs15_q);
          if (!cont_q && bt_cnt_q == PKT_NIBBLES - 8'h01) begin
            bt_q <= BT_GAP;
            bt_cnt_q <= 8'h00;
          end else begin
            bt_cnt_q <= bt_cnt_q + 8'h01;
          end
        end
        BT_GAP: begin
          if (bt_cnt_q == GAP_NIBBLES - 8'h01) begin
            bt_q <= BT_DATA;
            bt_cnt_q <= 8'h00;
          end else begin
            bt_cnt_q <= bt_cnt_q + 8'h01;
          end
        end
        default: begin
          bt_q <= BT_IDLE;
        end
      endcase
    end
  end

  // transmit source is the mac unless self-test runs; loopback feeds rx
  assign tx_en_src = bist_start_q ? (bt_q == BT_DATA) : s_txen;
  assign txd_src = bist_start_q ? gen_q[3:0] : s_txd;
  assign rx_dv_src = loopback_q ? tx_en_src : s_mdv;
  assign rxd_src = loopback_q ? txd_src : s_mrxd;
  assign rx_er_src = loopback_q ? 1'b0 : s_mer;

  // nibble-rate path: duplex never enters here, only crs/col see it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_act_q <= 1'b0;
      rxd_q <= 4'h0;
      rx_dv_q <= 1'b0;
      rx_er_q <= 1'b0;
      med_txd_q <= 4'h0;
      med_tx_en_q <= 1'b0;
    end else if (loopback_q && !tick) begin
      med_tx_en_q <= 1'b0;
      med_txd_q <= 4'h0;
    end else if (tick) begin
      tx_act_q <= tx_en_src;
      rxd_q <= rxd_src;
      rx_dv_q <= rx_dv_src;
      rx_er_q <= rx_er_src;
      med_tx_en_q <= tx_en_src & ~loopback_q;
      med_txd_q <= loopback_q ? 4'h0 : txd_src;
    end
  end

  // receive checker: its own lfsr, filled from the incoming stream
  assign {chk_miss, chk_d} = prbs_check(chk_q, rxd_src, prbs15_q);
  assign chk_on = tick && bist_start_q && rx_dv_src;
  assign mismatch = chk_on && (chk_fill_q == CHK_FILL) && chk_miss;
  assign good = chk_on && (chk_fill_q == CHK_FILL) && !chk_miss;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      chk_q <= 15'h0000;
      chk_fill_q <= 3'h0;
    end else if (!bist_start_q) begin
      chk_fill_q <= 3'h0;
    end else if (chk_on) begin
      chk_q <= chk_d;
      if (chk_fill_q != CHK_FILL) begin
        chk_fill_q <= chk_fill_q + 3'h1;
      end
    end
  end

  // pass/fail and error count; a miscompare beats a same-cycle clear
  assign err_base = pc_wr ? 8'h00 : err_cnt_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bist_pass_q <= 1'b0;
      bist_fail_q <= 1'b0;
      good_cnt_q <= 8'h00;
      err_cnt_q <= 8'h00;
    end else begin
      if (pc_wr) begin
        bist_pass_q <= 1'b0;
        bist_fail_q <= 1'b0;
        good_cnt_q <= 8'h00;
      end
      if (mismatch) begin
        bist_fail_q <= 1'b1;
        bist_pass_q <= 1'b0;
        good_cnt_q <= 8'h00;
      end else if (good && (pc_wr || !bist_fail_q)) begin
        if (good_cnt_q == PASS_NIBBLES - 8'h01) begin
          bist_pass_q <= 1'b1;
        end else begin
          good_cnt_q <= good_cnt_q + 8'h01;
        end
      end
      // saturate so a long failing run cannot wrap back to small values
      err_cnt_q <= err_base +
                   {7'h00, (mismatch && err_base != 8'hFF)};
    end
  end

  // 100 Mb/s carrier: detect valid, then zero, one, zero on the line
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      car100_q <= 1'b0;
      zero_q <= 1'b0;
      one_q <= 1'b0;
      dv_prev_q <= 1'b0;
    end else if (!s_sd || !speed100_q) begin
      car100_q <= 1'b0;
      zero_q <= 1'b0;
      one_q <= 1'b0;
      dv_prev_q <= 1'b0;
    end else if (tick) begin
      dv_prev_q <= s_mdv;
      if (car100_q) begin
        if (dv_prev_q && !s_mdv) begin
          car100_q <= 1'b0;
        end
      end else if (!s_line) begin
        if (one_q) begin
          car100_q <= 1'b1;
          zero_q <= 1'b0;
          one_q <= 1'b0;
        end else begin
          zero_q <= 1'b1;
        end
      end else if (zero_q) begin
        one_q <= 1'b1;
      end
    end
  end

  // receive activity: looped transmit, 100 carrier or 10 squelch
  assign rx_act = loopback_q ? tx_act_q :
                  (speed100_q ? car100_q : s_sq);
  assign coll_raw = ~full_dup_q & ~loopback_q & tx_act_q & rx_act;
  // 10 Mb/s collisions begun by our own transmit are delayed seven bits
  assign dly_now = coll_prev_q ? col_dly_q : (~speed100_q & ~rx_prev_q);
  assign col_live = coll_raw &&
                    (!dly_now || col_cnt_q >= COL_DELAY_CYC);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_prev_q <= 1'b0;
      tx_prev_q <= 1'b0;
      coll_prev_q <= 1'b0;
      col_dly_q <= 1'b0;
      col_cnt_q <= 6'h00;
    end else begin
      rx_prev_q <= rx_act;
      tx_prev_q <= tx_act_q;
      coll_prev_q <= coll_raw;
      col_dly_q <= dly_now;
      if (!coll_raw) begin
        col_cnt_q <= 6'h00;
      end else if (col_cnt_q != 6'h3F) begin
        col_cnt_q <= col_cnt_q + 6'h01;
      end
    end
  end

  // heartbeat: quiet gap after transmit ends, then a pulse on col
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hb_q <= HB_IDLE;
      hb_cnt_q <= 6'h00;
    end else begin
      case (hb_q)
        HB_IDLE: begin
          hb_cnt_q <= 6'h00;
          if (hb_en_q && !speed100_q && tx_prev_q && !tx_act_q) begin
            hb_q <= HB_WAIT;
          end
        end
        HB_WAIT: begin
          if (hb_cnt_q == HB_DELAY_CYC - 6'h01) begin
            hb_q <= HB_PULSE;
            hb_cnt_q <= 6'h00;
          end else begin
            hb_cnt_q <= hb_cnt_q + 6'h01;
          end
        end
        HB_PULSE: begin
          if (hb_cnt_q == HB_WIDTH_CYC - 6'h01) begin
            hb_q <= HB_IDLE;
            hb_cnt_q <= 6'h00;
          end else begin
            hb_cnt_q <= hb_cnt_q + 6'h01;
          end
        end
        default: begin
          hb_q <= HB_IDLE;
        end
      endcase
    end
  end

  // crs/col and the mii clocks, all registered
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      crs_q <= 1'b0;
      col_q <= 1'b0;
      tx_clk_q <= 1'b0;
      rx_clk_q <= 1'b0;
    end else begin
      crs_q <= rx_act | (~full_dup_q & tx_act_q);
      col_q <= ~full_dup_q & (col_live | (hb_q == HB_PULSE));
      tx_clk_q <= s_lclk;
      rx_clk_q <= s_lclk;
    end
  end

  assign reg_rdata = rdata_q;
  assign tx_clk = tx_clk_q;
  assign rx_clk = rx_clk_q;
  assign rxd = rxd_q;
  assign rx_dv = rx_dv_q;
  assign rx_er = rx_er_q;
  assign crs = crs_q;
  assign col = col_q;
  assign med_txd = med_txd_q;
  assign med_tx_en = med_tx_en_q;

  default clocking dc @(posedge clock); endclocking
  default disable iff (!rst_n);

  loop_no_media_a: assert property (loopback_q |=> !med_tx_en_q)
    else $error("medium driven during loopback");
  full_no_col_a: assert property (full_dup_q |=> !col_q)
    else $error("collision reported in full duplex");
  half_tx_crs_a: assert property ((!full_dup_q && tx_act_q) |=> crs_q)
    else $error("carrier missing for half duplex transmit");
  // a heartbeat pulse also raises col with no collision behind it
  col_delay_a: assert property (($rose(col_q) && $past(dly_now) &&
                                 $past(hb_q) != HB_PULSE) |->
                                $past(col_cnt_q) >= COL_DELAY_CYC)
    else $error("tx collision reported before seven bits");
  rx_col_now_a: assert property ((coll_raw && !dly_now) |=> col_q)
    else $error("receive collision not reported at once");
  col_hold_a: assert property ((col_q && coll_raw) |=> col_q)
    else $error("col dropped during collision");
  fail_latch_a: assert property ((bist_fail_q && !pc_wr) |=>
                                 (bist_fail_q && !bist_pass_q))
    else $error("self-test failure not held");
  err_count_a: assert property ((mismatch && !pc_wr &&
                                 err_cnt_q != 8'hFF) |=>
                                err_cnt_q == $past(err_cnt_q) + 8'h01)
    else $error("error count did not advance");
  status_rd_a: assert property ((reg_rd &&
                                 reg_addr == ADDR_PHY_STATUS) |=>
                                reg_rdata[PS_LOOPBACK_BIT] ==
                                $past(loopback_q))
    else $error("loopback status misread");
  loop_data_a: assert property ((tick && loopback_q &&
                                 !bist_start_q) |=>
                                (rx_dv_q == $past(s_txen) &&
                                 rxd_q == $past(s_txd)))
    else $error("looped nibble differs from transmit");
endmodule
`default_nettype wire

// file: pmd_mac_model.sv
// mac stand-in that drives the transmit side of the mii
// assumes tx_clk comes from the phy and is sampled on the core clock
`timescale 1ns/1ps
`default_nettype none
module pmd_mac_model (
  input wire logic clock, // core clock
  input wire logic rst_n, // async reset, active low
  input wire logic tx_clk, // transmit clock from the phy
  input wire logic go, // one-cycle frame request
  input wire logic [7:0] len, // nibbles in the frame
  output logic [3:0] mac_txd, // transmit nibble
  output logic mac_tx_en, // transmit enable
  output logic busy // frame in progress
);
  logic clk_q;
  logic [7:0] left_q;
  // nibbles count down from len to 1; after the frame the data pins invert
  // on every rising tx_clk edge, since a released bus holds no value
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      clk_q <= 1'b0;
      left_q <= 8'h00;
      mac_txd <= 4'h0;
      mac_tx_en <= 1'b0;
    end else begin
      clk_q <= tx_clk;
      if (go) begin
        left_q <= len;
      end else if (tx_clk && !clk_q) begin
        mac_tx_en <= left_q != 8'h00;
        mac_txd <= (left_q != 8'h00) ? left_q[3:0] : ~mac_txd;
        left_q <= (left_q != 8'h00) ? left_q - 8'h01 : 8'h00;
      end
    end
  end
  // frame still pending or on the wire
  assign busy = mac_tx_en || left_q != 8'h00;
endmodule
`default_nettype wire

// file: tb_phy_mii_duplex_loopback_bist.sv
// self-checking bench for the mii duplex, loopback and self-test core
// assumes pmd_pkg and pmd_mac_model are compiled before it
`timescale 1ns/1ps
`default_nettype none
module tb_phy_mii_duplex_loopback_bist;
  import pmd_pkg::*;
  logic clock = 0, rst_n = 0, link_clk = 0, reg_wr = 0, reg_rd = 0, go = 0;
  logic [4:0] reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, v;
  logic [7:0] len = 8'h00;
  logic [3:0] mac_txd, rxd, med_txd, med_rxd = 4'h0;
  logic mac_tx_en, tx_clk, rx_clk, rx_dv, rx_er, crs, col, med_tx_en, busy;
  logic med_rx_dv = 0, med_rx_er = 0, signal_detect = 0, squelch_valid = 0;
  logic med_line_bit = 0, p;
  int mismatches = 0, cmp_count = 0, cyc = 0, n, e;
  pmd_mii_core i_dut (.clock, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .link_clk, .mac_txd, .mac_tx_en, .tx_clk, .rx_clk,
    .rxd, .rx_dv, .rx_er, .crs, .col, .med_rxd, .med_rx_dv, .med_rx_er,
    .signal_detect, .squelch_valid, .med_line_bit, .med_txd, .med_tx_en);
  pmd_mac_model i_mac (.clock, .rst_n, .tx_clk, .go, .len, .mac_txd,
    .mac_tx_en, .busy);
  // 40 MHz core clock, 5 MHz link clock with its own phase
  always #12.5 clock = ~clock;
  always #100 link_clk = ~link_clk;
  // hang guard, far above the few thousand cycles the tests need
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      end_sim;
    end
  end
  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // sample a little after the edge so the design's updates have landed
  task automatic tick;
    @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic rdc(input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] d;
    rd(a, d);
    chk(d, exp);
  endtask
  // request a frame, then wait (bounded) until it is on the pins
  task automatic send(input logic [7:0] l);
    @(posedge clock);
    go <= 1'b1;
    len <= l;
    @(posedge clock);
    go <= 1'b0;
    for (int i = 0; i < 60 && !mac_tx_en; i++) tick;
  endtask
  task automatic idle_wait;
    for (int i = 0; i < 900 && busy; i++) tick;
    repeat (10) tick;
  endtask
  task automatic t_reset;
    rdc(ADDR_BASIC_CTRL, 16'h2000);
    rdc(ADDR_PHY_STATUS, 16'h0000);
    rdc(ADDR_PHY_CTRL, 16'h0000);
    rdc(ADDR_CABLE_DIAG, 16'h0000);
    wr(5'h05, 16'hFFFF);
    rdc(5'h05, 16'h0000);
    $display("test reset done");
  endtask
  // transmit reaches crs one link period after tx_en rises, syncing included
  task automatic t_carrier;
    wr(ADDR_BASIC_CTRL, 16'h0000);
    send(8'h14);
    repeat (10) tick;
    chk(16'(crs), 16'h0001);
    n = 0;
    p = tx_clk;
    repeat (80) begin
      tick;
      if (tx_clk && !p) n++;
      p = tx_clk;
    end
    chk(16'(n), 16'h000A);
    idle_wait;
    chk(16'(crs), 16'h0000);
    wr(ADDR_BASIC_CTRL, 16'h0100);
    send(8'h28);
    repeat (10) tick;
    chk(16'(crs), 16'h0000);
    @(posedge clock) squelch_valid <= 1'b1;
    repeat (40) tick;
    chk(16'(col), 16'h0000);
    chk(16'(crs), 16'h0001);
    @(posedge clock) squelch_valid <= 1'b0;
    idle_wait;
    $display("test carrier done");
  endtask
  task automatic t_collide;
    wr(ADDR_BASIC_CTRL, 16'h0000);
    send(8'h3C);
    repeat (6) tick;
    @(posedge clock) squelch_valid <= 1'b1;
    repeat (20) tick;
    chk(16'(col), 16'h0000);
    repeat (16) tick;
    chk(16'(col), 16'h0001);
    repeat (30) tick;
    chk(16'(col), 16'h0001);
    @(posedge clock) squelch_valid <= 1'b0;
    repeat (8) tick;
    chk(16'(col), 16'h0000);
    idle_wait;
    @(posedge clock) squelch_valid <= 1'b1;
    repeat (10) tick;
    send(8'h14);
    repeat (8) tick;
    chk(16'(col), 16'h0001);
    idle_wait;
    @(posedge clock) squelch_valid <= 1'b0;
    $display("test collision done");
  endtask
  task automatic t_loop;
    wr(ADDR_BASIC_CTRL, 16'h6000);
    rdc(ADDR_PHY_STATUS, 16'h0008);
    send(8'h08);
    e = 8;
    p = rx_clk;
    repeat (200) begin
      tick;
      if (rx_clk && !p && rx_dv) begin
        chk(16'(rxd), 16'(e));
        e--;
      end
      chk(16'(med_tx_en), 16'h0000);
      p = rx_clk;
    end
    chk(16'(e), 16'h0000);
    $display("test loopback done");
  endtask
  task automatic t_bist;
    wr(ADDR_PHY_CTRL, 16'h0100);
    repeat (600) tick;
    rdc(ADDR_PHY_CTRL, 16'h0300);
    rdc(ADDR_CABLE_DIAG, 16'h0000);
    // stop first: a length change mid-run would desync the checker
    wr(ADDR_PHY_CTRL, 16'h0000);
    wr(ADDR_PHY_CTRL, 16'h0500);
    repeat (600) tick;
    rdc(ADDR_PHY_CTRL, 16'h0700);
    wr(ADDR_PHY_CTRL, 16'h0000);
    $display("test self-test pass done");
  endtask
  task automatic t_fail;
    wr(ADDR_BASIC_CTRL, 16'h2000);
    wr(ADDR_CABLE_DIAG, 16'h0020);
    // all ones fits neither polynomial; zeros would lock the checker in
    @(posedge clock);
    med_rx_dv <= 1'b1;
    med_rxd <= 4'hF;
    wr(ADDR_PHY_CTRL, 16'h0100);
    repeat (100) tick;
    n = 0;
    repeat (2000) begin
      tick;
      if (med_tx_en !== 1'b1) n++;
    end
    chk(16'(n), 16'h0000);
    rdc(ADDR_PHY_CTRL, 16'h0100);
    rd(ADDR_CABLE_DIAG, v);
    chk({14'h0000, v[15:8] != 8'h00, v[5]}, 16'h0003);
    @(posedge clock);
    med_rx_dv <= 1'b0;
    med_rxd <= 4'h0;
    // let valid drain so no miscompare lands on the stop write
    repeat (4) tick;
    wr(ADDR_PHY_CTRL, 16'h0000);
    rdc(ADDR_CABLE_DIAG, 16'h0020);
    rdc(ADDR_PHY_CTRL, 16'h0000);
    wr(ADDR_CABLE_DIAG, 16'h0000);
    $display("test self-test fail done");
  endtask
  // 100 Mb/s carrier: detect, zero, one, zero; drops when valid falls
  task automatic t_car100;
    wr(ADDR_BASIC_CTRL, 16'h2100);
    @(posedge clock) signal_detect <= 1'b1;
    repeat (24) tick;
    chk(16'(crs), 16'h0000);
    @(posedge clock) med_line_bit <= 1'b1;
    repeat (24) tick;
    @(posedge clock) med_line_bit <= 1'b0;
    @(posedge clock) med_rx_dv <= 1'b1;
    repeat (24) tick;
    chk(16'(crs), 16'h0001);
    @(posedge clock) med_rx_dv <= 1'b0;
    repeat (24) tick;
    chk(16'(crs), 16'h0000);
    @(posedge clock) signal_detect <= 1'b0;
    $display("test 100 carrier done");
  endtask
  task automatic t_heart;
    wr(ADDR_BASIC_CTRL, 16'h0000);
    wr(ADDR_PHY_CTRL, 16'h0080);
    send(8'h04);
    n = 0;
    repeat (300) begin
      tick;
      if (col === 1'b1) n++;
    end
    chk(16'(n), 16'h0028);
    $display("test heartbeat done");
  endtask
  // reset for two cycles, then the scenarios in turn
  initial begin
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    t_reset;
    t_carrier;
    t_collide;
    t_loop;
    t_bist;
    t_fail;
    t_car100;
    t_heart;
    end_sim;
  end
endmodule
`default_nettype wire
